//--- rdfp_pkg.sv
// constants, types and behaviour notes for the radio data buffer pair
package rdfp_pkg;

    localparam int DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;

    localparam logic [CNT_W-1:0] TX_THR_BASE = 7'h3d;
    localparam logic [CNT_W-1:0] THR_STEP    = 7'h04;
    localparam logic [3:0]       THR_RESET   = 4'h7;
    localparam logic [3:0]       FILL_CAP    = 4'hf;

    // register port offsets
    localparam logic [7:0] REG_THR_CFG   = 8'h00;
    localparam logic [7:0] REG_RX_STATUS = 8'h04;
    localparam logic [7:0] REG_TX_STATUS = 8'h08;
    localparam logic [7:0] REG_FLUSH     = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR   = 8'h14;
    localparam logic [7:0] REG_IRQ_EN    = 8'h18;

    // flush register bits
    localparam int FLUSH_RX_BIT = 0;
    localparam int FLUSH_TX_BIT = 1;

    // interrupt status bits
    localparam int IRQ_RX_OVF  = 0;
    localparam int IRQ_TX_UNF  = 1;
    localparam int IRQ_RX_THR  = 2;
    localparam int IRQ_TX_LOW  = 3;
    localparam int IRQ_W       = 4;

    // serial header: bit 7 set means read, bits 5:0 are the address
    localparam int HDR_READ_BIT = 7;
    localparam logic [5:0] SPI_BUF_ADDR   = 6'h3f;
    localparam logic [5:0] SPI_TXCNT_ADDR = 6'h3a;
    localparam logic [5:0] SPI_RXCNT_ADDR = 6'h3b;
    localparam logic [2:0] BIT_LAST       = 3'h7;

    typedef struct packed {
        logic cs_b;
        logic sclk;
        logic mosi;
    } rdfp_spi_in_type;

endpackage : rdfp_pkg

//--- rdfp_top.sv
// radio data buffer pair with serial host port and register port
`timescale 1ns/1ps
`default_nettype none

module rdfp_top #(
    parameter int DEPTH = rdfp_pkg::DEPTH
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    input  wire rdfp_pkg::rdfp_spi_in_type spi_in,
    output logic                          spi_miso,
    output logic                          spi_miso_oe,
    input  wire logic                     rx_push,
    input  wire logic [7:0]               rx_push_data,
    input  wire logic                     tx_pop,
    output logic      [7:0]               tx_pop_data,
    input  wire logic                     sleep_req,
    output logic      [1:0]               general_output_pin,
    output logic                          irq
);

    localparam int PW = rdfp_pkg::PTR_W;
    localparam int CW = rdfp_pkg::CNT_W;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [CW-1:0] ONE  = 7'h01;

    // storage and pointers
    logic [7:0]    rx_mem_q [DEPTH];
    logic [7:0]    tx_mem_q [DEPTH];
    logic [PW-1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
    logic [CW-1:0] rx_cnt_q, tx_cnt_q;
    logic          rx_ovf_q, tx_unf_q;

    // register state
    logic [3:0]          thr_sel_q;
    logic [rdfp_pkg::IRQ_W-1:0] irq_st_q, irq_en_q;
    logic                rx_flag_q, tx_flag_q;

    // serial state
    logic [2:0] cs_sync_q, sclk_sync_q;
    logic [1:0] mosi_sync_q;
    logic [2:0] bit_q;
    logic [7:0] in_sr_q, out_sr_q, hdr_q;
    logic       in_hdr_q, reload_q;

    // --- serial pin conditioning: first stage feeds only the second
    wire cs_act    = ~cs_sync_q[1];
    wire cs_start  = ~cs_sync_q[1] & cs_sync_q[2];
    wire sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    wire sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
    wire mosi_s    = mosi_sync_q[1];

    wire       byte_done = cs_act & sclk_rise & (bit_q == rdfp_pkg::BIT_LAST);
    wire [7:0] in_byte   = {in_sr_q[6:0], mosi_s};
    wire       hdr_rd    = hdr_q[rdfp_pkg::HDR_READ_BIT];
    wire       hdr_buf   = hdr_q[5:0] == rdfp_pkg::SPI_BUF_ADDR;
    wire       data_done = byte_done & ~in_hdr_q;
    wire       spi_rx_pop  = data_done & hdr_rd & hdr_buf;
    wire       spi_tx_push = data_done & ~hdr_rd & hdr_buf;
    wire       hdr_done    = byte_done & in_hdr_q;
    wire       hdr_next_rd = in_byte[rdfp_pkg::HDR_READ_BIT];
    wire       hdr_next_buf = in_byte[5:0] == rdfp_pkg::SPI_BUF_ADDR;

    // --- register port decode
    wire wr_thr   = reg_wr & (reg_addr == rdfp_pkg::REG_THR_CFG);
    wire wr_flush = reg_wr & (reg_addr == rdfp_pkg::REG_FLUSH);
    wire wr_clr   = reg_wr & (reg_addr == rdfp_pkg::REG_IRQ_CLR);
    wire wr_en    = reg_wr & (reg_addr == rdfp_pkg::REG_IRQ_EN);
    wire flush_rx = (wr_flush & reg_wdata[rdfp_pkg::FLUSH_RX_BIT]) | sleep_req;
    wire flush_tx = (wr_flush & reg_wdata[rdfp_pkg::FLUSH_TX_BIT]) | sleep_req;

    // --- receive buffer control
    wire rx_full   = rx_cnt_q == FULL;
    wire rx_wr     = rx_push & ~rx_full;
    wire rx_ovf_ev = rx_push & rx_full;
    // an empty read leaves everything alone and returns the stale head byte
    wire rx_rd     = spi_rx_pop & (rx_cnt_q != '0);
    // pointer slip when the last byte leaves as a new one lands
    wire rx_rp_adv = rx_rd & ~(rx_wr & (rx_cnt_q == ONE));
    wire [CW-1:0] rx_cnt_d = rx_cnt_q + CW'(rx_wr) - CW'(rx_rd);

    // --- transmit buffer control
    wire tx_full   = tx_cnt_q == FULL;
    wire tx_wr     = spi_tx_push & ~tx_full;
    wire tx_rd     = tx_pop & (tx_cnt_q != '0);
    wire tx_unf_ev = tx_pop & (tx_cnt_q == '0);
    wire [CW-1:0] tx_cnt_d = tx_cnt_q + CW'(tx_wr) - CW'(tx_rd);

    // --- thresholds
    wire [CW-1:0] thr_n     = {3'h0, thr_sel_q};
    wire [CW-1:0] tx_thr    = CW'(rdfp_pkg::TX_THR_BASE - rdfp_pkg::THR_STEP * thr_n);
    wire [CW-1:0] rx_thr    = CW'(rdfp_pkg::THR_STEP * (thr_n + ONE));
    wire          rx_flag_d = rx_cnt_q >= rx_thr;
    wire          tx_flag_d = tx_cnt_q >= tx_thr;

    // --- events and interrupt status
    wire [rdfp_pkg::IRQ_W-1:0] irq_ev = {tx_flag_q & ~tx_flag_d, rx_flag_d & ~rx_flag_q,
                                         tx_unf_ev, rx_ovf_ev};
    wire [rdfp_pkg::IRQ_W-1:0] irq_clr = wr_clr ? reg_wdata[rdfp_pkg::IRQ_W-1:0] : '0;
    // a new event in the clearing cycle survives the clear
    wire [rdfp_pkg::IRQ_W-1:0] irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;

    // --- status byte fill fields, capped at fifteen
    wire [3:0] rx_fill = (rx_cnt_q > CW'(rdfp_pkg::FILL_CAP)) ? rdfp_pkg::FILL_CAP : rx_cnt_q[3:0];
    wire [3:0] tx_fill = (tx_cnt_q > CW'(rdfp_pkg::FILL_CAP)) ? rdfp_pkg::FILL_CAP : tx_cnt_q[3:0];
    wire [7:0] stat_byte = {1'b0, rx_ovf_q | tx_unf_q, 2'b00, rx_fill};

    // --- readable count fields, error flag in bit 7
    wire [7:0] rx_status = {rx_ovf_q, rx_cnt_q};
    wire [7:0] tx_status = {tx_unf_q, tx_cnt_q};

    // --- reply byte chosen at the end of the header
    wire [7:0] hdr_reply = (in_byte[5:0] == rdfp_pkg::SPI_RXCNT_ADDR) ? rx_status :
                           (in_byte[5:0] == rdfp_pkg::SPI_TXCNT_ADDR) ? tx_status : 8'h00;

    // --- register read mux
    wire [7:0] rd_mux =
        (reg_addr == rdfp_pkg::REG_THR_CFG)   ? {4'h0, thr_sel_q} :
        (reg_addr == rdfp_pkg::REG_RX_STATUS) ? rx_status :
        (reg_addr == rdfp_pkg::REG_TX_STATUS) ? tx_status :
        (reg_addr == rdfp_pkg::REG_IRQ_STAT)  ? {4'h0, irq_st_q} :
        (reg_addr == rdfp_pkg::REG_IRQ_EN)    ? {4'h0, irq_en_q} : 8'h00;

    assign spi_miso    = out_sr_q[7];
    assign spi_miso_oe = cs_act;
    assign irq         = |(irq_st_q & irq_en_q);

    // --- pin synchronisers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_q   <= 3'h7;
            sclk_sync_q <= 3'h0;
            mosi_sync_q <= 2'h0;
        end else begin
            cs_sync_q   <= {cs_sync_q[1:0], spi_in.cs_b};
            sclk_sync_q <= {sclk_sync_q[1:0], spi_in.sclk};
            mosi_sync_q <= {mosi_sync_q[0], spi_in.mosi};
        end
    end

    // --- serial shifter, mode 0: sample on rise, shift out on fall
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_q    <= 3'h0;
            in_sr_q  <= 8'h00;
            out_sr_q <= 8'h00;
            hdr_q    <= 8'h00;
            in_hdr_q <= 1'b1;
            reload_q <= 1'b0;
        end else if (!cs_act) begin
            bit_q    <= 3'h0;
            in_hdr_q <= 1'b1;
            reload_q <= 1'b0;
        end else begin
            reload_q <= 1'b0;
            if (cs_start) begin
                out_sr_q <= stat_byte;
            end else if (reload_q) begin
                out_sr_q <= rx_mem_q[rx_rp_q];
            end else if (byte_done) begin
                if (in_hdr_q && !hdr_next_buf) begin
                    out_sr_q <= hdr_next_rd ? hdr_reply : 8'h00;
                end
            end else if (sclk_rise && in_hdr_q && bit_q == 3'h0) begin
                // the read/write bit has just arrived: pick which fill to report
                out_sr_q[3:0] <= mosi_s ? rx_fill : tx_fill;
            end else if (sclk_fall && bit_q != 3'h0) begin
                // no shift right after a byte: its first bit is already out
                out_sr_q <= {out_sr_q[6:0], 1'b0};
            end
            if (sclk_rise) begin
                bit_q   <= bit_q + 3'h1;
                in_sr_q <= in_byte;
            end
            if (hdr_done) begin
                hdr_q    <= in_byte;
                in_hdr_q <= 1'b0;
                reload_q <= hdr_next_rd & hdr_next_buf;
            end
            if (spi_rx_pop) begin
                // next byte fetched one cycle after the pop settles
                reload_q <= 1'b1;
            end
        end
    end

    // --- receive buffer pointers, count and sticky overflow
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
            rx_ovf_q <= 1'b0;
        end else if (flush_rx) begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
            // an overflow in the flushing cycle still shows: set beats clear
            rx_ovf_q <= rx_ovf_ev;
        end else begin
            rx_wp_q  <= rx_wp_q + PW'(rx_wr);
            rx_rp_q  <= rx_rp_q + PW'(rx_rp_adv);
            rx_cnt_q <= rx_cnt_d;
            rx_ovf_q <= rx_ovf_q | rx_ovf_ev;
        end
    end

    // --- transmit buffer pointers, count and sticky underflow
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_wp_q  <= '0;
            tx_rp_q  <= '0;
            tx_cnt_q <= '0;
            tx_unf_q <= 1'b0;
        end else if (flush_tx) begin
            tx_wp_q  <= '0;
            tx_rp_q  <= '0;
            tx_cnt_q <= '0;
            tx_unf_q <= tx_unf_ev;
        end else begin
            tx_wp_q  <= tx_wp_q + PW'(tx_wr);
            tx_rp_q  <= tx_rp_q + PW'(tx_rd);
            tx_cnt_q <= tx_cnt_d;
            tx_unf_q <= tx_unf_q | tx_unf_ev;
        end
    end

    // --- byte storage, one entry per write enable
    for (genvar i = 0; i < DEPTH; i++) begin : g_mem
        always_ff @(posedge core_clk) begin
            if (rx_wr && rx_wp_q == PW'(i)) begin
                rx_mem_q[i] <= rx_push_data;
            end
            if (tx_wr && tx_wp_q == PW'(i)) begin
                tx_mem_q[i] <= in_byte;
            end
        end
    end

    // --- modem-side transmit data, held until the next pop that finds data
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_pop_data <= 8'h00;
        end else if (tx_rd) begin
            tx_pop_data <= tx_mem_q[tx_rp_q];
        end
    end

    // --- configuration, interrupts, flags and register read data
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            thr_sel_q          <= rdfp_pkg::THR_RESET;
            irq_st_q           <= '0;
            irq_en_q           <= '0;
            rx_flag_q          <= 1'b0;
            tx_flag_q          <= 1'b0;
            general_output_pin <= 2'h0;
            reg_rdata          <= 8'h00;
        end else begin
            if (wr_thr) begin
                thr_sel_q <= reg_wdata[3:0];
            end
            if (wr_en) begin
                irq_en_q <= reg_wdata[rdfp_pkg::IRQ_W-1:0];
            end
            irq_st_q           <= irq_st_d;
            rx_flag_q          <= rx_flag_d;
            tx_flag_q          <= tx_flag_d;
            general_output_pin <= {tx_flag_d, rx_flag_d};
            reg_rdata          <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule : rdfp_top

`default_nettype wire

//--- rdfp_sva.sv
// concurrent checks on the buffer pair ports
`timescale 1ns/1ps
`default_nettype none
module rdfp_sva (
    input wire logic                      core_clk,
    input wire logic                      rst_b,
    input wire logic [7:0]                reg_addr,
    input wire logic [7:0]                reg_wdata,
    input wire logic                      reg_wr,
    input wire logic                      reg_rd,
    input wire logic [7:0]                reg_rdata,
    input wire rdfp_pkg::rdfp_spi_in_type spi_in,
    input wire logic                      spi_miso_oe,
    input wire logic                      rx_push,
    input wire logic                      tx_pop,
    input wire logic [7:0]                tx_pop_data,
    input wire logic                      sleep_req,
    input wire logic [1:0]                general_output_pin,
    input wire logic                      irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire thr_wr = reg_wr && reg_addr == rdfp_pkg::REG_THR_CFG;
    wire thr_rd = reg_rd && reg_addr == rdfp_pkg::REG_THR_CFG;
    wire fl_rx  = reg_wr && reg_addr == rdfp_pkg::REG_FLUSH && reg_wdata[0];
    wire rx_rd  = reg_rd && reg_addr == rdfp_pkg::REG_RX_STATUS;
    wire en_off = reg_wr && reg_addr == rdfp_pkg::REG_IRQ_EN && reg_wdata == 8'h00;
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_pop_hold;
        !$past(tx_pop) |-> $stable(tx_pop_data);
    endproperty
    a_pop_hold: assert property (p_pop_hold) else $error("send byte moved without pop");
    property p_oe_on;
        $fell(spi_in.cs_b) |-> ##[1:4] spi_miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("serial output not driven");
    property p_oe_off;
        spi_in.cs_b [*4] |-> !spi_miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("serial output driven unselected");
    property p_thr_rb;
        thr_wr ##1 !reg_wr ##1 thr_rd |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 3)};
    endproperty
    a_thr_rb: assert property (p_thr_rb) else $error("threshold select readback");
    property p_flush_rx;
        fl_rx && !rx_push ##1 !rx_push ##1 rx_rd |=> reg_rdata == 8'h00;
    endproperty
    a_flush_rx: assert property (p_flush_rx) else $error("flush left count or error");
    property p_sleep;
        sleep_req [*4] |-> general_output_pin == 2'b00;
    endproperty
    a_sleep: assert property (p_sleep) else $error("flags set while asleep");
    property p_irq_off;
        en_off |-> ##[1:2] !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt high with all masked");
    c_pop: cover property (tx_pop ##1 !tx_pop);
    c_frame: cover property ($fell(spi_in.cs_b));
    c_rx_flag: cover property ($rose(general_output_pin[0]));
endmodule : rdfp_sva
bind rdfp_top rdfp_sva sva_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .spi_in(spi_in), .spi_miso_oe(spi_miso_oe), .rx_push(rx_push), .tx_pop(tx_pop),
    .tx_pop_data(tx_pop_data), .sleep_req(sleep_req),
    .general_output_pin(general_output_pin), .irq(irq));
`default_nettype wire

//--- rdfp_host_model.sv
// serial host model: master side of the buffer access link
`timescale 1ns/1ps
`default_nettype none
module rdfp_host_model (
    input  wire logic                     core_clk,
    output var rdfp_pkg::rdfp_spi_in_type spi_in,
    input  wire logic                     spi_miso,
    input  wire logic                     spi_miso_oe
);
    logic last_q = 1'b0;
    // no pull on the line: a released line shows the inverse of its last level
    wire  line = spi_miso_oe ? spi_miso : ~last_q;
    initial spi_in = '{cs_b: 1'b1, sclk: 1'b0, mosi: 1'b0};
    always @(posedge core_clk) if (spi_miso_oe) last_q <= spi_miso;
    // odd delay keeps link edges off the core clock grid
    task automatic sel(input logic on);
        #43 spi_in.cs_b = ~on;
        #43;
    endtask : sel
    // mode 0, 64 ns bit: sample mid-high, well clear of the change after the fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_in.mosi = tx[i];
            #32 spi_in.sclk = 1'b1;
            #16 rx[i] = line;
            #16 spi_in.sclk = 1'b0;
        end
    endtask : xfer
endmodule : rdfp_host_model
`default_nettype wire

//--- rdfp_top_bench.sv
// self-checking bench for the radio data buffer pair
`timescale 1ns/1ps
`default_nettype none
module rdfp_top_bench;
    logic                      core_clk = 1'b0;
    logic                      rst_b = 1'b0;
    logic [7:0]                reg_addr = 8'h00;
    logic [7:0]                reg_wdata = 8'h00;
    logic                      reg_wr = 1'b0;
    logic                      reg_rd = 1'b0;
    logic                      rx_push = 1'b0;
    logic [7:0]                rx_push_data = 8'h00;
    logic                      tx_pop = 1'b0;
    logic                      sleep_req = 1'b0;
    logic [7:0]                reg_rdata, tx_pop_data, rd_v;
    logic                      spi_miso, spi_miso_oe, irq;
    logic [1:0]                gpo;
    rdfp_pkg::rdfp_spi_in_type spi_in;
    int                        bad_count = 0;
    int                        compares = 0;
    rdfp_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .spi_in(spi_in), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .rx_push(rx_push),
        .rx_push_data(rx_push_data), .tx_pop(tx_pop), .tx_pop_data(tx_pop_data),
        .sleep_req(sleep_req), .general_output_pin(gpo), .irq(irq));
    rdfp_host_model host_u (.core_clk(core_clk), .spi_in(spi_in), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe));
    initial forever #4 core_clk = ~core_clk;
    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rr(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, reg_rdata);
    endtask : rr
    task automatic push(input logic [7:0] d);
        @(posedge core_clk);
        rx_push      <= 1'b1;
        rx_push_data <= d;
        @(posedge core_clk);
        rx_push <= 1'b0;
    endtask : push
    task automatic pop(input logic [7:0] e);
        @(posedge core_clk);
        tx_pop <= 1'b1;
        @(posedge core_clk);
        tx_pop <= 1'b0;
        #1 chk("send byte", e, tx_pop_data);
    endtask : pop
    // count and pin each take a register stage; the pin is loaded from the unregistered flag
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rr(rdfp_pkg::REG_THR_CFG, 8'h07);
        rr(rdfp_pkg::REG_RX_STATUS, 8'h00);
        rr(rdfp_pkg::REG_TX_STATUS, 8'h00);
        rr(8'h20, 8'h00);
        chk("pins", 8'h00, {5'h00, irq, gpo});
        for (int n = 0; n < 16; n++) begin
            wr(rdfp_pkg::REG_THR_CFG, 8'(n));
            rr(rdfp_pkg::REG_THR_CFG, 8'(n));
        end
        for (int i = 0; i < 63; i++) push(8'(i));
        settle();
        chk("rx flag", 8'h00, {7'h00, gpo[0]});
        push(8'h3f);
        settle();
        chk("rx flag", 8'h01, {7'h00, gpo[0]});
        rr(rdfp_pkg::REG_RX_STATUS, 8'h40);
        push(8'haa);
        rr(rdfp_pkg::REG_RX_STATUS, 8'hc0);
        rr(rdfp_pkg::REG_IRQ_STAT, 8'h05);
        chk("irq", 8'h00, {7'h00, irq});
        wr(rdfp_pkg::REG_IRQ_EN, 8'h01);
        settle();
        chk("irq", 8'h01, {7'h00, irq});
        wr(rdfp_pkg::REG_IRQ_CLR, 8'h01);
        settle();
        chk("irq", 8'h00, {7'h00, irq});
        host_u.sel(1'b1);
        host_u.xfer(8'hff, rd_v);
        chk("status", 8'h4f, rd_v);
        for (int i = 0; i < 3; i++) begin
            host_u.xfer(8'h00, rd_v);
            chk("rx byte", 8'(i), rd_v);
        end
        host_u.sel(1'b0);
        rr(rdfp_pkg::REG_RX_STATUS, 8'hbd);
        wr(rdfp_pkg::REG_FLUSH, 8'h01);
        rr(rdfp_pkg::REG_RX_STATUS, 8'h00);
        push(8'h5a);
        push(8'h5b);
        // rx count is 2 here, so the write header must switch the fill to tx
        host_u.sel(1'b1);
        host_u.xfer(8'h3f, rd_v);
        chk("status", 8'h00, rd_v);
        host_u.xfer(8'h11, rd_v);
        host_u.xfer(8'h22, rd_v);
        host_u.sel(1'b0);
        rr(rdfp_pkg::REG_TX_STATUS, 8'h02);
        settle();
        chk("tx flag", 8'h01, {7'h00, gpo[1]});
        wr(rdfp_pkg::REG_THR_CFG, 8'h0e);
        settle();
        chk("tx flag", 8'h00, {7'h00, gpo[1]});
        pop(8'h11);
        pop(8'h22);
        pop(8'h22);
        rr(rdfp_pkg::REG_TX_STATUS, 8'h80);
        rr(rdfp_pkg::REG_IRQ_STAT, 8'h0e);
        wr(rdfp_pkg::REG_IRQ_EN, 8'h0f);
        settle();
        chk("irq", 8'h01, {7'h00, irq});
        wr(rdfp_pkg::REG_IRQ_EN, 8'h00);
        settle();
        chk("irq", 8'h00, {7'h00, irq});
        wr(rdfp_pkg::REG_FLUSH, 8'h02);
        rr(rdfp_pkg::REG_TX_STATUS, 8'h00);
        @(posedge core_clk);
        sleep_req <= 1'b1;
        repeat (5) @(posedge core_clk);
        sleep_req <= 1'b0;
        rr(rdfp_pkg::REG_RX_STATUS, 8'h00);
        // one-byte packet fully landed before any read
        push(8'h33);
        host_u.sel(1'b1);
        host_u.xfer(8'hbb, rd_v);
        chk("status", 8'h01, rd_v);
        host_u.xfer(8'h00, rd_v);
        chk("rx count reply", 8'h01, rd_v);
        host_u.sel(1'b0);
        host_u.sel(1'b1);
        host_u.xfer(8'hff, rd_v);
        chk("status", 8'h01, rd_v);
        // land a byte in the very cycle the serial read takes the last one
        fork
            host_u.xfer(8'h00, rd_v);
            begin
                repeat (8) @(posedge spi_in.sclk);
                @(posedge core_clk);
                push(8'h44);
            end
        join
        chk("rx byte", 8'h33, rd_v);
        rr(rdfp_pkg::REG_RX_STATUS, 8'h01);
        host_u.xfer(8'h00, rd_v);
        chk("rx byte", 8'h33, rd_v);
        host_u.sel(1'b0);
        rr(rdfp_pkg::REG_RX_STATUS, 8'h00);
        report_and_stop();
    end
endmodule : rdfp_top_bench
`default_nettype wire
